//--- src/ctt_capture_timer_trigger_ctrl.sv
// Trigger and sync control of one capture channel's timer
`timescale 1ns/1ns
`include "ctt_map.svh"

module ctt_capture_timer_trigger_ctrl
  import ctt_pkg::*;
#(
  parameter int CHANNEL  = 1,  // Channel number, 1 to 4
  parameter int NUM_SRCS = 32  // Number of selectable sources
)
(
  input  wire logic                 clk,               // 10 MHz clock
  input  wire logic                 reset_n,           // Synchronous reset, low
  input  wire logic                 ctrl_wr,           // Write strobe for control two
  input  wire logic [15:0]          ctrl_wdata,        // Write data for control two
  input  wire logic [NUM_SRCS-1:0]  src_events,        // Source event pulses
  input  wire logic [3:0]           trig_gen_outputs,  // Generator outputs 8 to 11
  input  wire logic                 peer_cascade,      // Partner channel cascade bit
  output logic [15:0]               capture_control_two, // Register read value
  output logic                      timer_trigger_status, // Trigger status flag; timer runs on it in trigger mode only
  output logic                      timer_run,         // Timer may count
  output logic                      timer_hold_clear,  // Timer held at zero
  output logic                      timer_sync_pulse,  // Reset timer for sync mode
  output logic                      cascade_active     // Pair forms 32-bit unit
);

  ////////////////////////////////////////////////////////////////////////////
  // Elaboration checks

  // Only four generator outputs exist, one for each channel
  if (CHANNEL < 1 || CHANNEL > 4)
  begin : g_bad_channel
    $error("CHANNEL must be 1 to 4");
  end

  // The select field is five bits wide, so no more than 32 sources
  if (NUM_SRCS < 1 || NUM_SRCS > 32)
  begin : g_bad_srcs
    $error("NUM_SRCS must be 1 to 32");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Design notes
  //
  // The selected event is registered once before it touches the status
  // flag, so the flag rises two clocks after the event is seen. This costs
  // one clock of latency but keeps the wide select mux off the flag path.
  //
  // A hardware set and a software clear in the same clock resolve in
  // favour of the set, so an event can never be lost to a racing write.
  //
  // Nothing stops software from naming this channel as its own source;
  // doing so loops the channel onto itself and is left to software.
  //
  // Cascade is only reported active when the partner channel agrees, so a
  // half-configured pair stays as two independent channels.

  ////////////////////////////////////////////////////////////////////////////
  // Field decoding

  // Source select field of a control word, used for reset and writes
  function automatic logic [4:0] sel_field(input ctt_word_t w);
    sel_field = w[`CTT_SEL_MSB:`CTT_SEL_LSB];
  endfunction : sel_field

  // Reset image kept as a typed word so each field is picked by position
  localparam ctt_word_t  RESET_WORD   = `CTT_RESET_CTRL2;
  localparam logic       RESET_CASC   = RESET_WORD[`CTT_BIT_CASCADE];
  localparam logic       RESET_MODE   = RESET_WORD[`CTT_BIT_TRIG_MODE];
  localparam logic       RESET_STATUS = RESET_WORD[`CTT_BIT_TRIG_STATUS];
  localparam logic [4:0] RESET_SEL    = sel_field(RESET_WORD);

  ////////////////////////////////////////////////////////////////////////////
  // Source selection

  logic       src_hit;
  wire logic [31:0] src_all;
  logic       src_q;     // Registered so the status set lands two clocks after the event
  logic       src_d;
  logic       cascade_q, cascade_d;
  logic       mode_q,    mode_d;
  logic       status_q,  status_d;
  logic [4:0] sel_q,     sel_d;

  // generator output for this channel
  // Generator output folds into code 0; unused codes read as quiet
  for (genvar i = 0; i < 32; i++)
  begin : g_src
    if (i == 0)
    begin : g_code0
      // Only this channel's generator output, never a neighbour's
      assign src_all[i] = src_events[0] | trig_gen_outputs[CHANNEL-1];
    end
    else if (i < NUM_SRCS)
    begin : g_used
      assign src_all[i] = src_events[i];
    end
    else
    begin : g_spare
      // Codes beyond the fitted sources never fire
      assign src_all[i] = 1'b0;
    end
  end

  // no self-source guard; software must avoid
  always_comb
  begin
    src_hit = src_all[sel_q];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control register next state

  always_comb
  begin
    src_d     = src_hit;
    cascade_d = cascade_q;
    mode_d    = mode_q;
    sel_d     = sel_q;
    status_d  = status_q;
    if (ctrl_wr)
    begin
      cascade_d = ctrl_wdata[`CTT_BIT_CASCADE];
      mode_d    = ctrl_wdata[`CTT_BIT_TRIG_MODE];
      sel_d     = sel_field(ctrl_wdata);
      status_d  = ctrl_wdata[`CTT_BIT_TRIG_STATUS];
    end
    if (src_q && mode_q == CTT_TRIG)
      status_d = 1'b1;
  end

  // Registers only
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      src_q     <= 1'b0;
      cascade_q <= RESET_CASC;
      mode_q    <= RESET_MODE;
      status_q  <= RESET_STATUS;
      sel_q     <= RESET_SEL;
    end
    else
    begin
      src_q     <= src_d;
      cascade_q <= cascade_d;
      mode_q    <= mode_d;
      status_q  <= status_d;
      sel_q     <= sel_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  always_comb
  begin
    capture_control_two = '0;
    capture_control_two[`CTT_BIT_CASCADE]     = cascade_q;
    capture_control_two[`CTT_BIT_TRIG_MODE]   = mode_q;
    capture_control_two[`CTT_BIT_TRIG_STATUS] = status_q;
    capture_control_two[`CTT_SEL_MSB:`CTT_SEL_LSB] = sel_q;
  end

  // trigger versus sync
  // In sync mode the timer free runs and is only restarted by the pulse
  always_comb
  begin
    timer_trigger_status = status_q;
    if (mode_q == CTT_TRIG)
    begin
      timer_run        = status_q;
      timer_hold_clear = !status_q;
      timer_sync_pulse = 1'b0;
    end
    else
    begin
      timer_run        = 1'b1;
      timer_hold_clear = 1'b0;
      timer_sync_pulse = src_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Cascade

  assign cascade_active = cascade_q && peer_cascade;

endmodule : ctt_capture_timer_trigger_ctrl

//--- src/ctt_map.svh
// Constants for the capture timer trigger control block
`ifndef CTT_MAP_SVH
`define CTT_MAP_SVH
`define CTT_BIT_CASCADE     8
`define CTT_BIT_TRIG_MODE   7
`define CTT_BIT_TRIG_STATUS 6
`define CTT_BIT_UNUSED      5
`define CTT_SEL_MSB         4
`define CTT_SEL_LSB         0
`define CTT_RESET_CTRL2     16'h000D
`define CTT_SEL_WIDTH       5
`define CTT_TRIG_GEN_BASE   8
`endif

//--- src/ctt_pkg.sv
// Types for the capture timer trigger control block
package ctt_pkg;
  typedef logic [15:0] ctt_word_t;
  typedef enum logic [0:0]
  {
    CTT_SYNC = 1'b0,
    CTT_TRIG = 1'b1
  } ctt_mode_e;
endpackage : ctt_pkg

//--- verification/ctt_checker.sv
// Port checker for the capture timer trigger control
`timescale 1ns/1ns
module ctt_checker #(parameter int CHANNEL = 1, parameter int NUM_SRCS = 32)
 (input logic clk, reset_n, ctrl_wr, peer_cascade, timer_trigger_status, timer_run,
  input logic timer_hold_clear, timer_sync_pulse, cascade_active, input logic [3:0] trig_gen_outputs,
  input logic [15:0] ctrl_wdata, capture_control_two, input logic [NUM_SRCS-1:0] src_events);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // Selected source fired with no write racing it
  wire trg = capture_control_two[7];
  wire hit = src_events[capture_control_two[4:0]] && !ctrl_wr;
  property p_hold; trg |-> timer_run == timer_trigger_status && timer_hold_clear == !timer_trigger_status; endproperty
  a_hold: assert property (p_hold) else $error("run or hold wrong");
  property p_swset; ctrl_wr && ctrl_wdata[6] |=> timer_trigger_status; endproperty
  a_swset: assert property (p_swset) else $error("status not set by write");
  property p_src; trg && hit ##1 !ctrl_wr |=> timer_trigger_status; endproperty
  a_src: assert property (p_src) else $error("source did not trigger");
  property p_gen; trg && capture_control_two[4:0] == 0 && trig_gen_outputs[CHANNEL-1] && !ctrl_wr
    ##1 !ctrl_wr |=> timer_trigger_status; endproperty
  a_gen: assert property (p_gen) else $error("generator did not trigger");
  property p_unused; capture_control_two[15:9] == 0 && !capture_control_two[5]; endproperty
  a_unused: assert property (p_unused) else $error("unused bit not zero");
  property p_sync; !trg && hit |=> timer_sync_pulse && timer_run; endproperty
  a_sync: assert property (p_sync) else $error("no sync pulse");
  property p_casc; cascade_active == (capture_control_two[8] && peer_cascade); endproperty
  a_casc: assert property (p_casc) else $error("cascade wrong");
endmodule : ctt_checker

//--- verification/ctt_src_model.sv
// Model of the event sources and trigger generator
`timescale 1ns/1ns
module ctt_src_model (input logic clk, output logic [31:0] ev = 0, output logic [3:0] gen = 0);
  task fire(input int n, input bit g); @(posedge clk);
    if (g) gen[n] <= 1; else ev[n] <= 1;
    @(posedge clk); ev <= 0; gen <= 0; endtask : fire
endmodule : ctt_src_model

//--- verification/tb_top.sv
// Self-checking bench for the capture timer trigger control
`timescale 1ns/1ns
module tb_top;
  import ctt_pkg::*;
  logic clk = 0, reset_n = 0, ctrl_wr = 0, peer_cascade = 0;
  ctt_word_t ctrl_wdata = 0, rd, q[$];
  logic [31:0] ev; logic [3:0] gen; logic [4:0] sel;
  int num_errors = 0, n_checks = 0, cyc = 0;
  always #50 clk = ~clk;
  ctt_src_model u_src(.clk(clk), .ev(ev), .gen(gen));
  ctt_capture_timer_trigger_ctrl #(.CHANNEL(2)) u_dut(.clk(clk), .reset_n(reset_n),
    .ctrl_wr(ctrl_wr), .ctrl_wdata(ctrl_wdata), .src_events(ev), .trig_gen_outputs(gen),
    .peer_cascade(peer_cascade), .capture_control_two(rd), .timer_trigger_status(),
    .timer_run(), .timer_hold_clear(), .timer_sync_pulse(), .cascade_active());
  task wr(input ctt_word_t d); @(posedge clk); ctrl_wr <= 1; ctrl_wdata <= d;
    @(posedge clk); ctrl_wr <= 0; endtask : wr
  task exp(input ctt_word_t v); q.push_back(v); endtask : exp
  task cmp(input ctt_word_t v); n_checks++;
    if (rd !== v) begin num_errors++; $display("BAD %0t reg %h exp %h", $time, rd, v); end
  endtask : cmp
  // Oldest note meets the settled register value
  always @(negedge clk) while (q.size()) cmp(q.pop_front());
  task give_verdict; $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish; endtask : give_verdict
  // Hang guard, tests need well under this
  always @(posedge clk) if (++cyc == 3000) begin num_errors++; give_verdict; end
  initial begin
    void'($urandom(32'h9407B1D8));
    repeat (8) @(posedge clk); reset_n <= 1;
    @(posedge clk); exp(16'h000D);
    wr(16'hFFBF); exp(16'h019F);
    $display("reset and fields done");
    sel = 5'($urandom_range(31, 1));
    wr(16'h0080 | sel); u_src.fire(sel ^ 5'h1, 0); @(posedge clk); exp(16'h0080 | sel);
    u_src.fire(sel, 0); @(posedge clk); exp(16'h00C0 | sel);
    wr(16'h0080 | sel); exp(16'h0080 | sel);
    wr(16'h00C0 | sel); exp(16'h00C0 | sel);
    $display("trigger done");
    wr(16'h0080); u_src.fire(0, 1); @(posedge clk); exp(16'h0080);
    u_src.fire(1, 1); @(posedge clk); exp(16'h00C0);
    $display("generator done");
    wr(16'(sel)); u_src.fire(sel, 0); @(posedge clk); exp(16'(sel));
    wr(16'h0100); peer_cascade <= 1; @(posedge clk); exp(16'h0100);
    $display("sync and cascade done");
    reset_n <= 0; @(posedge clk); reset_n <= 1; @(posedge clk); exp(16'h000D);
    $display("second reset done");
    repeat (2) @(posedge clk); give_verdict;
  end
endmodule : tb_top
bind ctt_capture_timer_trigger_ctrl ctt_checker #(.CHANNEL(CHANNEL), .NUM_SRCS(NUM_SRCS)) u_chk(.*);
